// file: cmss_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the clock and module-stop block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Included by bare name; definitions only
`ifndef CMSS_DEFS_SVH
`define CMSS_DEFS_SVH

`define CMSS_OFS_STOP_A 12'h000
`define CMSS_OFS_STOP_C 12'h004
`define CMSS_OFS_OSC_CTRL 12'h008
`define CMSS_OFS_MAIN_WAIT 12'h00C
`define CMSS_OFS_PLL_WAIT 12'h010
`define CMSS_OFS_PLL_CFG 12'h014
`define CMSS_OFS_CLK_DIV 12'h018
`define CMSS_OFS_CLK_SEL 12'h01C
`define CMSS_OFS_STATUS 12'h020

`define CMSS_BIT_STOP_DMA 28
`define CMSS_BIT_STOP_EXT_DMA 29
`define CMSS_BIT_STOP_RAM0 0
`define CMSS_BIT_STOP_RAM1 1

`define CMSS_BIT_MAIN_EN 0
`define CMSS_BIT_PLL_EN 1
`define CMSS_BIT_FAST_ONCHIP_OSCILLATOR_RUN 2
`define CMSS_BIT_FAST_ONCHIP_OSCILLATOR_PWR 3
`define CMSS_BIT_SUB_EN 4
`define CMSS_BIT_RTC_SUB 5

`define CMSS_WAIT_W 5
`define CMSS_DIV_FW 4
`define CMSS_NUM_DIV 6

`define CMSS_RST_STOP 1'b0
`define CMSS_RST_OSC_CTRL 6'h00
`define CMSS_RST_WAIT 5'h00
`define CMSS_RST_PLL_DIV 2'h0
`define CMSS_RST_PLL_MUL 6'h0F
`define CMSS_RST_CLK_DIV 24'h2222_11
`define CMSS_RST_CLK_SEL 2'h0

`define CMSS_SYS_CLK_NS 10
`define CMSS_FAST_ONCHIP_OSCILLATOR_WAIT_NS 2000
`define CMSS_FAST_ONCHIP_OSCILLATOR_WAIT_CYC ((`CMSS_FAST_ONCHIP_OSCILLATOR_WAIT_NS + `CMSS_SYS_CLK_NS - 1) / `CMSS_SYS_CLK_NS)
`define CMSS_SUB_WAIT_CYC 64
`define CMSS_MAIN_EXTRA_CYC 16384
`define CMSS_PLL_EXTRA_CYC 131072

`endif

// file: cmss_pkg.sv
// Purpose: Types of the clock and module-stop block
// Assumes: Used with cmss_defs.svh
// Notes: Clock source codes match the select field
package cmss_pkg;
  typedef enum logic [1:0] {
    CMSS_SRC_FAST_ONCHIP_OSCILLATOR = 2'h0,
    CMSS_SRC_MAIN = 2'h1,
    CMSS_SRC_SUB = 2'h2,
    CMSS_SRC_PLL = 2'h3
  } cmss_src_e;

  typedef enum logic [1:0] {
    CMSS_SW_IDLE = 2'h0,
    CMSS_SW_GATE_OFF = 2'h1,
    CMSS_SW_SWITCH = 2'h3,
    CMSS_SW_GATE_ON = 2'h2
  } cmss_sw_e;
endpackage

// file: cmss_osc_wait.sv
// Purpose: Stabilisation wait after an oscillator is enabled
// Assumes: Wait code counts 2**code cycles, then EXTRA_CYC more
// Notes: Dropping enable clears the stable flag at once
`timescale 1ns/1ps
`include "cmss_defs.svh"
module cmss_osc_wait #(
  parameter int unsigned EXTRA_CYC = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic osc_enable, // Oscillator enabled
  input wire logic [`CMSS_WAIT_W-1:0] wait_code, // Programmed wait code
  output logic stable // Output may reach internal clock
);
  logic [32:0] cnt_reg;
  logic [32:0] target;

  assign target = (33'h0_0000_0001 << wait_code) + 33'(EXTRA_CYC);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 33'h0_0000_0000;
      stable <= 1'b0;
    end else if (!osc_enable) begin
      cnt_reg <= 33'h0_0000_0000;
      stable <= 1'b0;
    end else if (!stable) begin
      cnt_reg <= cnt_reg + 33'h0_0000_0001;
      stable <= (cnt_reg + 33'h0_0000_0001) >= target;
    end
  end
endmodule // cmss_osc_wait

// file: cmss_div_tick.sv
// Purpose: One divided clock enable
// Assumes: Ratio code r divides by 2**r (0 to 7)
// Notes: A new ratio takes effect at once; a count already at or past its end wraps on the next cycle
`timescale 1ns/1ps
`include "cmss_defs.svh"
module cmss_div_tick (
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic run, // Source clock gated on
  input wire logic [`CMSS_DIV_FW-1:0] ratio, // Division code
  output logic tick // One pulse per divided period
);
  logic [6:0] cnt_reg;
  logic [6:0] last;

  // Eight bits before the cut so that code 7 still gives 127 and not 63
  assign last = 7'((8'h01 << ratio[2:0]) - 8'h01);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 7'h00;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // cmss_div_tick

// file: cmss_top.sv
// Purpose: Oscillator bring-up, clock source switch, dividers and module-stop bits
// Assumes: APB slave, one wait state on every access
// Notes: Oscillators are modelled by their enable and a counted stabilisation wait
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cmss_defs.svh"

// Summary of operation
// - Four module-stop bits reset to zero
// - Writing one stops module, zero runs
// - Main clock withheld until wait elapses
// - PLL withheld until its wait elapses
// - Six separate divider ratios, example 2 and 4
// - Fast oscillator run and power separately
// - Main wait adds 16384 cycles
// - PLL wait adds 131072 cycles
module cmss_top
  import cmss_pkg::*;
#(
  parameter int unsigned MAIN_EXTRA_CYC = `CMSS_MAIN_EXTRA_CYC,
  parameter int unsigned PLL_EXTRA_CYC = `CMSS_PLL_EXTRA_CYC
) (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  output logic stop_bit_dma_transfer, // Transfer engine stopped
  output logic stop_bit_ext_dma, // External DMA engine stopped
  output logic stop_bit_ram_block0, // RAM block 0 stopped
  output logic stop_bit_ram_block1, // RAM block 1 stopped
  output logic main_osc_enable, // Main oscillator enable
  output logic sub_osc_enable, // Sub-clock oscillator enable
  output logic pll_enable, // PLL enable
  output logic [1:0] pll_in_div, // PLL input division code
  output logic [5:0] pll_mul, // PLL multiplication code
  output logic fast_onchip_oscillator_run, // Fast oscillator running
  output logic fast_onchip_oscillator_pwr, // Fast oscillator supply on
  output logic rtc_src_sub, // RTC counts sub-clock when high
  output logic [1:0] sys_clk_src, // Active system clock source
  output logic sys_clk_gate, // System clock gate open
  output logic [`CMSS_NUM_DIV-1:0] div_tick // Core, A, B, bus, flash, bus-ctrl enables
);
  logic [`CMSS_NUM_DIV*`CMSS_DIV_FW-1:0] clk_div_reg;
  logic [`CMSS_WAIT_W-1:0] main_wait_reg;
  logic [`CMSS_WAIT_W-1:0] pll_wait_reg;
  cmss_src_e sel_req_reg;
  cmss_src_e active_reg;
  cmss_sw_e sw_state_reg;
  logic main_stable;
  logic pll_stable;
  logic fast_onchip_oscillator_ready;
  logic sub_stable;
  logic src_ready;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rd_next;

  // APB decode
  always_comb begin
    hit = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      `CMSS_OFS_STOP_A: begin
        rd_next[`CMSS_BIT_STOP_DMA] = stop_bit_dma_transfer;
        rd_next[`CMSS_BIT_STOP_EXT_DMA] = stop_bit_ext_dma;
      end
      `CMSS_OFS_STOP_C: begin
        rd_next[`CMSS_BIT_STOP_RAM0] = stop_bit_ram_block0;
        rd_next[`CMSS_BIT_STOP_RAM1] = stop_bit_ram_block1;
      end
      `CMSS_OFS_OSC_CTRL: begin
        rd_next[`CMSS_BIT_MAIN_EN] = main_osc_enable;
        rd_next[`CMSS_BIT_PLL_EN] = pll_enable;
        rd_next[`CMSS_BIT_FAST_ONCHIP_OSCILLATOR_RUN] = fast_onchip_oscillator_run;
        rd_next[`CMSS_BIT_FAST_ONCHIP_OSCILLATOR_PWR] = fast_onchip_oscillator_pwr;
        rd_next[`CMSS_BIT_SUB_EN] = sub_osc_enable;
        rd_next[`CMSS_BIT_RTC_SUB] = rtc_src_sub;
      end
      `CMSS_OFS_MAIN_WAIT: rd_next[`CMSS_WAIT_W-1:0] = main_wait_reg;
      `CMSS_OFS_PLL_WAIT: rd_next[`CMSS_WAIT_W-1:0] = pll_wait_reg;
      `CMSS_OFS_PLL_CFG: rd_next[13:0] = {pll_mul, 6'h00, pll_in_div};
      `CMSS_OFS_CLK_DIV: rd_next[`CMSS_NUM_DIV*`CMSS_DIV_FW-1:0] = clk_div_reg;
      `CMSS_OFS_CLK_SEL: rd_next[1:0] = sel_req_reg;
      `CMSS_OFS_STATUS: rd_next[7:0] = {sw_state_reg != CMSS_SW_IDLE, active_reg, sub_stable,
                                        fast_onchip_oscillator_ready, pll_stable, main_stable, 1'b0};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  assign wr_en = psel & penable & pready & pwrite & hit;
  assign rd_en = psel & penable & ~pready;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rd_en;
      pslverr <= rd_en & ~hit;
      prdata <= (rd_en & ~pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_bit_dma_transfer <= `CMSS_RST_STOP;
      stop_bit_ext_dma <= `CMSS_RST_STOP;
      stop_bit_ram_block0 <= `CMSS_RST_STOP;
      stop_bit_ram_block1 <= `CMSS_RST_STOP;
    end else if (wr_en && paddr == `CMSS_OFS_STOP_A) begin
      stop_bit_dma_transfer <= pwdata[`CMSS_BIT_STOP_DMA];
      stop_bit_ext_dma <= pwdata[`CMSS_BIT_STOP_EXT_DMA];
    end else if (wr_en && paddr == `CMSS_OFS_STOP_C) begin
      stop_bit_ram_block0 <= pwdata[`CMSS_BIT_STOP_RAM0];
      stop_bit_ram_block1 <= pwdata[`CMSS_BIT_STOP_RAM1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {rtc_src_sub, sub_osc_enable, fast_onchip_oscillator_pwr, fast_onchip_oscillator_run,
       pll_enable, main_osc_enable} <= `CMSS_RST_OSC_CTRL;
    end else if (wr_en && paddr == `CMSS_OFS_OSC_CTRL) begin
      main_osc_enable <= pwdata[`CMSS_BIT_MAIN_EN];
      pll_enable <= pwdata[`CMSS_BIT_PLL_EN];
      fast_onchip_oscillator_run <= pwdata[`CMSS_BIT_FAST_ONCHIP_OSCILLATOR_RUN];
      fast_onchip_oscillator_pwr <= pwdata[`CMSS_BIT_FAST_ONCHIP_OSCILLATOR_PWR];
      sub_osc_enable <= pwdata[`CMSS_BIT_SUB_EN];
      rtc_src_sub <= pwdata[`CMSS_BIT_RTC_SUB];
    end
  end

  // Wait codes and PLL ratios; software must set them before enabling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_wait_reg <= `CMSS_RST_WAIT;
      pll_wait_reg <= `CMSS_RST_WAIT;
      pll_in_div <= `CMSS_RST_PLL_DIV;
      pll_mul <= `CMSS_RST_PLL_MUL;
    end else if (wr_en) begin
      if (paddr == `CMSS_OFS_MAIN_WAIT) begin
        main_wait_reg <= pwdata[`CMSS_WAIT_W-1:0];
      end
      if (paddr == `CMSS_OFS_PLL_WAIT) begin
        pll_wait_reg <= pwdata[`CMSS_WAIT_W-1:0];
      end
      if (paddr == `CMSS_OFS_PLL_CFG) begin
        pll_in_div <= pwdata[1:0];
        pll_mul <= pwdata[13:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_div_reg <= `CMSS_RST_CLK_DIV;
    end else if (wr_en && paddr == `CMSS_OFS_CLK_DIV) begin
      clk_div_reg <= pwdata[`CMSS_NUM_DIV*`CMSS_DIV_FW-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_req_reg <= cmss_src_e'(`CMSS_RST_CLK_SEL);
    end else if (wr_en && paddr == `CMSS_OFS_CLK_SEL) begin
      sel_req_reg <= cmss_src_e'(pwdata[1:0]);
    end
  end

  cmss_osc_wait #(
    .EXTRA_CYC(MAIN_EXTRA_CYC)
  ) u_main_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(main_osc_enable),
    .wait_code(main_wait_reg),
    .stable(main_stable)
  );

  cmss_osc_wait #(
    .EXTRA_CYC(PLL_EXTRA_CYC)
  ) u_pll_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(pll_enable & main_stable),
    .wait_code(pll_wait_reg),
    .stable(pll_stable)
  );

  cmss_osc_wait #(
    .EXTRA_CYC(`CMSS_FAST_ONCHIP_OSCILLATOR_WAIT_CYC)
  ) u_fast_onchip_oscillator_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(fast_onchip_oscillator_run & fast_onchip_oscillator_pwr),
    .wait_code(`CMSS_RST_WAIT),
    .stable(fast_onchip_oscillator_ready)
  );

  cmss_osc_wait #(
    .EXTRA_CYC(`CMSS_SUB_WAIT_CYC)
  ) u_sub_wait (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .osc_enable(sub_osc_enable),
    .wait_code(`CMSS_RST_WAIT),
    .stable(sub_stable)
  );

  always_comb begin
    case (sel_req_reg)
      CMSS_SRC_FAST_ONCHIP_OSCILLATOR: src_ready = fast_onchip_oscillator_ready;
      CMSS_SRC_MAIN: src_ready = main_stable;
      CMSS_SRC_SUB: src_ready = sub_stable;
      CMSS_SRC_PLL: src_ready = pll_stable;
      default: src_ready = 1'b0;
    endcase
  end

  // stable source only
  // Gate closes for three cycles around the change so no short pulse escapes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_state_reg <= CMSS_SW_IDLE;
      active_reg <= cmss_src_e'(`CMSS_RST_CLK_SEL);
      sys_clk_gate <= 1'b1;
    end else begin
      case (sw_state_reg)
        CMSS_SW_IDLE: begin
          if (sel_req_reg != active_reg && src_ready) begin
            sw_state_reg <= CMSS_SW_GATE_OFF;
            sys_clk_gate <= 1'b0;
          end
        end
        CMSS_SW_GATE_OFF: begin
          sw_state_reg <= CMSS_SW_SWITCH;
        end
        CMSS_SW_SWITCH: begin
          // Request withdrawn or source lost: stay on the old source
          if (src_ready) begin
            active_reg <= sel_req_reg;
          end
          sw_state_reg <= CMSS_SW_GATE_ON;
        end
        CMSS_SW_GATE_ON: begin
          sys_clk_gate <= 1'b1;
          sw_state_reg <= CMSS_SW_IDLE;
        end
        default: begin
          sw_state_reg <= CMSS_SW_IDLE;
          sys_clk_gate <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_clk_src <= `CMSS_RST_CLK_SEL;
    end else begin
      sys_clk_src <= active_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CMSS_NUM_DIV; gi++) begin : g_div
      cmss_div_tick u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(sys_clk_gate),
        .ratio(clk_div_reg[gi*`CMSS_DIV_FW +: `CMSS_DIV_FW]),
        .tick(div_tick[gi])
      );
    end
  endgenerate
endmodule // cmss_top

// file: cmss_top_sva.sv
// Purpose: Port-level assertions for the clock and module-stop block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Stabilisation counters restart whenever an enable drops
`timescale 1ns/1ps
`include "cmss_defs.svh"
module cmss_top_sva
  import cmss_pkg::*;
#(
  parameter int unsigned MAIN_EXTRA_CYC = 16,
  parameter int unsigned PLL_EXTRA_CYC = 16
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic stop_bit_dma_transfer, // Stop bit
  input wire logic stop_bit_ext_dma, // Stop bit
  input wire logic stop_bit_ram_block0, // Stop bit
  input wire logic stop_bit_ram_block1, // Stop bit
  input wire logic main_osc_enable, // Main enable
  input wire logic pll_enable, // PLL enable
  input wire logic [1:0] sys_clk_src, // Active source
  input wire logic sys_clk_gate, // Gate open
  input wire logic [`CMSS_NUM_DIV-1:0] div_tick // Divided enables
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] main_on_cnt;
  logic [31:0] pll_on_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) main_on_cnt <= '0;
    else main_on_cnt <= main_osc_enable ? main_on_cnt + 1 : '0;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) pll_on_cnt <= '0;
    else pll_on_cnt <= pll_enable ? pll_on_cnt + 1 : '0;
  end
  sequence s_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  property p_ready_wait; s_access |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ready");
  property p_stop_hold;
    !(psel && penable && pready && pwrite) |=>
      $stable({stop_bit_dma_transfer, stop_bit_ext_dma, stop_bit_ram_block0, stop_bit_ram_block1});
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop bit moved without write");
  property p_gate_low; $fell(sys_clk_gate) |=> !sys_clk_gate [*2] ##1 sys_clk_gate; endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate low time wrong");
  property p_src_gated; $changed(sys_clk_src) |-> !$past(sys_clk_gate); endproperty
  a_src_gated: assert property (p_src_gated) else $error("source changed with gate open");
  property p_no_tick; !sys_clk_gate && !$past(sys_clk_gate) |-> div_tick == '0; endproperty
  a_no_tick: assert property (p_no_tick) else $error("tick while gated");
  property p_main_wait;
    $changed(sys_clk_src) && sys_clk_src == CMSS_SRC_MAIN |-> main_on_cnt >= MAIN_EXTRA_CYC;
  endproperty
  a_main_wait: assert property (p_main_wait) else $error("main used before wait");
  property p_pll_wait;
    $changed(sys_clk_src) && sys_clk_src == CMSS_SRC_PLL |-> pll_on_cnt >= PLL_EXTRA_CYC;
  endproperty
  a_pll_wait: assert property (p_pll_wait) else $error("PLL used before wait");
endmodule // cmss_top_sva

bind cmss_top cmss_top_sva #(.MAIN_EXTRA_CYC(MAIN_EXTRA_CYC), .PLL_EXTRA_CYC(PLL_EXTRA_CYC)) i_cmss_top_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_bit_dma_transfer(stop_bit_dma_transfer),
  .stop_bit_ext_dma(stop_bit_ext_dma), .stop_bit_ram_block0(stop_bit_ram_block0),
  .stop_bit_ram_block1(stop_bit_ram_block1), .main_osc_enable(main_osc_enable), .pll_enable(pll_enable),
  .sys_clk_src(sys_clk_src), .sys_clk_gate(sys_clk_gate), .div_tick(div_tick));

// file: tb_top.sv
// Purpose: Self-checking bench for the clock and module-stop block
// Assumes: Short stabilisation counts set through parameters
// Notes: Wait windows allow a few cycles of switch latency
`timescale 1ns/1ps
`include "cmss_defs.svh"
module tb_top;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic stop_bit_dma_transfer, stop_bit_ext_dma, stop_bit_ram_block0, stop_bit_ram_block1;
  logic main_osc_enable, sub_osc_enable, pll_enable, rtc_src_sub, sys_clk_gate;
  logic fast_onchip_oscillator_run, fast_onchip_oscillator_pwr;
  logic [1:0] pll_in_div, sys_clk_src;
  logic [5:0] pll_mul, div_tick;
  int errors = 0;
  int checked = 0;
  cmss_top #(.MAIN_EXTRA_CYC(20), .PLL_EXTRA_CYC(40)) i_cmss_top (.sys_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_bit_dma_transfer, .stop_bit_ext_dma,
    .stop_bit_ram_block0, .stop_bit_ram_block1, .main_osc_enable, .sub_osc_enable, .pll_enable, .pll_in_div,
    .pll_mul, .fast_onchip_oscillator_run, .fast_onchip_oscillator_pwr, .rtc_src_sub, .sys_clk_src,
    .sys_clk_gate, .div_tick);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    chk("ready", n < 20, 1);
  endtask
  task t_reset;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), '0);
      chk("reset value", rd_q, i == 5 ? 32'h0000_0F00 : i == 6 ? 32'h0022_2211 : '0);
    end
    chk("stop bits", {stop_bit_dma_transfer, stop_bit_ext_dma, stop_bit_ram_block0, stop_bit_ram_block1}, 0);
    chk("gate", {sys_clk_gate, sys_clk_src}, 4);
    $display("test reset done");
  endtask
  task t_stop;
    apb(1'b1, `CMSS_OFS_STOP_A, 32'h3000_0000);
    chk("stop a", {stop_bit_dma_transfer, stop_bit_ext_dma}, 3);
    apb(1'b0, `CMSS_OFS_STOP_A, '0);
    chk("stop a read", rd_q, 32'h3000_0000);
    apb(1'b1, `CMSS_OFS_STOP_C, 32'h0000_0003);
    chk("stop c", {stop_bit_ram_block0, stop_bit_ram_block1}, 3);
    apb(1'b1, `CMSS_OFS_STOP_A, '0);
    apb(1'b1, `CMSS_OFS_STOP_C, 32'h0000_0001);
    chk("stop all", {stop_bit_dma_transfer, stop_bit_ext_dma, stop_bit_ram_block0, stop_bit_ram_block1}, 2);
    $display("test stop done");
  endtask
  task t_err;
    apb(1'b1, 12'h024, 32'hFFFF_FFFF);
    chk("unmapped write", err_q, 1);
    apb(1'b0, 12'h024, '0);
    chk("unmapped read error", err_q, 1);
    chk("unmapped read data", rd_q, 32'h0000_0000);
    apb(1'b1, `CMSS_OFS_STATUS, 32'hFFFF_FFFF);
    chk("status write", err_q, 0);
    $display("test error done");
  endtask
  task t_tick(input int b, input int per);
    int n;
    n = 0;
    while (div_tick[b] !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (div_tick[b] !== 1'b1 && n < 100);
    chk("tick period", n, per);
    $display("test tick done");
  endtask
  task t_switch(input logic [1:0] src, input logic [31:0] osc, input int min);
    int n;
    n = 0;
    // Enable first: the gate can only fall after the select lands, four cycles after the enable
    apb(1'b1, `CMSS_OFS_OSC_CTRL, osc);
    apb(1'b1, `CMSS_OFS_CLK_SEL, 32'(src));
    while (sys_clk_gate === 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    chk("stable wait", n >= min - 4 && n <= min + 1, 1);
    repeat (5) @(posedge sys_clk);
    chk("source", {sys_clk_gate, sys_clk_src}, {1'b1, src});
    $display("test switch done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500_000;
    errors++;
    finish_test();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tick(0, 2);
    t_tick(2, 4);
    t_stop();
    t_err();
    // Main as source forbids divide by 1 or 2; peripheral B stays well above the RTC source
    apb(1'b1, `CMSS_OFS_CLK_DIV, 32'h0022_2222);
    // Wait first, then enable, with main requested while still unstable
    apb(1'b1, `CMSS_OFS_MAIN_WAIT, 32'h0000_0002);
    t_switch(2'h1, 32'h0000_0001, 24);
    t_switch(2'h2, 32'h0000_0031, 65);
    chk("rtc source", rtc_src_sub, 1);
    chk("osc enables", {main_osc_enable, sub_osc_enable, pll_enable}, 6);
    apb(1'b1, `CMSS_OFS_PLL_WAIT, 32'h0000_0001);
    apb(1'b1, `CMSS_OFS_PLL_CFG, 32'h0000_0F01);
    chk("pll cfg", {pll_mul, pll_in_div}, 8'h3D);
    t_switch(2'h3, 32'h0000_0033, 42);
    apb(1'b1, `CMSS_OFS_CLK_DIV, 32'h0022_2213);
    t_tick(0, 8);
    t_switch(2'h0, 32'h0000_000F, 201);
    chk("fast osc on", {fast_onchip_oscillator_run, fast_onchip_oscillator_pwr}, 3);
    // Leave the fast oscillator only after the system clock has moved to the PLL
    t_switch(2'h3, 32'h0000_000F, 0);
    apb(1'b1, `CMSS_OFS_OSC_CTRL, 32'h0000_000B);
    chk("fast osc run off", {fast_onchip_oscillator_run, fast_onchip_oscillator_pwr}, 1);
    apb(1'b1, `CMSS_OFS_OSC_CTRL, 32'h0000_0003);
    chk("fast osc off", {fast_onchip_oscillator_run, fast_onchip_oscillator_pwr}, 0);
    apb(1'b0, `CMSS_OFS_STATUS, '0);
    chk("status", rd_q, 32'h0000_0066);
    finish_test();
  end
endmodule // tb_top
